// File: hw/qdc_params.svh
// qdc_params.svh: offsets, field positions, word codes and sizes of the event readout
// assumes: included by its bare name from the package and the design modules
`ifndef QDC_PARAMS_SVH
`define QDC_PARAMS_SVH

// register offsets
`define QDC_OFF_BUF_HI   16'h07FC
`define QDC_OFF_FWREV    16'h1000
`define QDC_OFF_GEO      16'h1002
`define QDC_OFF_STAT1    16'h100E
`define QDC_OFF_BSET2    16'h1032
`define QDC_OFF_BCLR2    16'h1034
`define QDC_OFF_CRATE    16'h103C
`define QDC_OFF_THR_LO   16'h1080
`define QDC_OFF_THR_HI   16'h10BF
`define QDC_MCST_LO      16'h1006
`define QDC_MCST_HI      16'h10BF

// values and reset values
`define QDC_FW_REV       16'h5A3C // arbitrary value, names no real release
`define QDC_GEO_RST      5'h1F
`define QDC_CRATE_RST    8'h00
`define QDC_BS2_RST      16'h0000
`define QDC_THR_RST      9'h000

// word type codes, bits 26..24
`define QDC_TYPE_HDR     3'h2
`define QDC_TYPE_DATA    3'h0
`define QDC_TYPE_TRAIL   3'h4
`define QDC_TYPE_NVD     3'h6

// field positions
`define QDC_BS2_OVF_BIT  3
`define QDC_BS2_UND_BIT  4
`define QDC_THR_KILL_BIT 8
`define QDC_ST_DRDY_BIT  0
`define QDC_ST_BUSY_BIT  2
`define QDC_ST_MISS_BIT  4

// buffer size in words and worst-case event length
`define QDC_BUF_WORDS    512
`define QDC_EVT_MAX      10'h022

`endif

// File: hw/qdc_pkg.sv
// qdc_pkg: types shared by the event readout modules
// assumes: qdc_params.svh on the include path
`include "qdc_params.svh"

package qdc_pkg;
	// event assembly states, gray along idle-scan-head-tail
	typedef enum logic [1:0] {
		ST_IDLE = 2'h0,
		ST_SCAN = 2'h1,
		ST_HEAD = 2'h3,
		ST_TAIL = 2'h2
	} asm_state_t;
	typedef logic [31:0] buf_word_t;
endpackage

// File: hw/qdc_buf_if.sv
// qdc_buf_if: link between event assembly and the multi-event store
// assumes: both ends on the same clock
`timescale 1ns/1ps
`default_nettype none

interface qdc_buf_if;
	import qdc_pkg::*;
	logic       wr_en;
	logic [5:0] wr_off;
	buf_word_t  wr_data;
	logic       commit;
	logic [5:0] commit_len;
	logic       rd_en;
	buf_word_t  rd_data;
	logic       empty;
	logic       room;
	modport mem (input wr_en, wr_off, wr_data, commit, commit_len, rd_en,
		output rd_data, empty, room);
	modport fmt (output wr_en, wr_off, wr_data, commit, commit_len, rd_en,
		input rd_data, empty, room);
endinterface

`default_nettype wire

// File: hw/qdc_event_mem.sv
// qdc_event_mem: circular word store; writes land past the published end until committed
// assumes: reader pops only when not empty, writer checks room before an event
`timescale 1ns/1ps
`default_nettype none
`include "qdc_params.svh"

module qdc_event_mem
	import qdc_pkg::*;
(
	// clock and reset
	input  wire logic i_clk,
	input  wire logic i_reset,
	// store port
	qdc_buf_if.mem    bus
);
	buf_word_t  mem_q [0:`QDC_BUF_WORDS-1];
	logic [9:0] wptr_q;
	logic [9:0] rptr_q;
	logic [9:0] used;

	// published words only; a dropped event never moves the write pointer
	assign used      = wptr_q - rptr_q;
	assign bus.empty = (used == 10'h000);
	assign bus.room  = (used <= 10'(`QDC_BUF_WORDS) - `QDC_EVT_MAX);
	assign bus.rd_data = mem_q[rptr_q[8:0]];

	// word write relative to the published end
	always_ff @(posedge i_clk) begin
		if (bus.wr_en) begin
			mem_q[wptr_q[8:0] + {3'h0, bus.wr_off}] <= bus.wr_data;
		end
	end

	// pointers
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			wptr_q <= 10'h000;
			rptr_q <= 10'h000;
		end else begin
			if (bus.commit) begin
				wptr_q <= wptr_q + {4'h0, bus.commit_len};
			end
			if (bus.rd_en && !bus.empty) begin
				rptr_q <= rptr_q + 10'h001; // oldest word first
			end
		end
	end
endmodule

`default_nettype wire

// File: hw/qdc_event_buffer_readout.sv
// qdc_event_buffer_readout: formats converted charges into events and serves register reads
// assumes: single-cycle access strobes from the bus front end, converter results valid with
// i_gate_done, slot pins and connector sense asynchronous
`timescale 1ns/1ps
`default_nettype none
`include "qdc_params.svh"

// Operation
// - every buffer entry is read out as one 32-bit word
// - event is header, data words, then trailer after all data
// - slot position sits in bits 31..27 of every stored word
// - type field 26..24: header 010, data 000, trailer 100, empty 110
// - header bits 23..16 carry the crate number register
// - header bits 13..8 carry the stored channel count
// - channel number in bits 20..16, or 20..17 for sixteen channels
// - data bit 13 set when value is below channel threshold
// - data bit 12 set when the converter overflowed
// - data bits 11..0 carry the 12-bit converted value
// - trailer bits 23..0 carry the 24-bit event counter
// - reading an empty buffer returns a word typed 110
// - channels stored interleaved: 0,16,1,17 or 0,8,1,9
// - overflowed, under-threshold or disabled channels are skipped
// - control bits 3 and 4 keep overflow and under-threshold data
// - with suppression and no channel kept, nothing stored, pointer unchanged
// - buffer window 0x0000 to 0x07FC is read only
// - multicast takes only 16-bit writes from 0x1006 to 0x10BF
// - slot register writable only when the backplane gives no slot
// - firmware revision is a 16-bit read-only value
// - registers take 16-bit access only, buffer takes 32-bit
module qdc_event_buffer_readout
	import qdc_pkg::*;
#(
	parameter bit CH32 = 1'b1
)
(
	// clock and reset
	input  wire logic         i_clk,
	input  wire logic         i_reset,
	// register access
	input  wire logic         i_rd,
	input  wire logic         i_wr,
	input  wire logic         i_wide,
	input  wire logic         i_mcst,
	input  wire logic [15:0]  i_addr,
	input  wire logic [15:0]  i_wdata,
	output logic              o_ack,
	output logic              o_berr,
	output logic [31:0]       o_rdata,
	// conversion results
	input  wire logic         i_gate_done,
	input  wire logic [383:0] i_adc,
	input  wire logic [31:0]  i_ovf,
	// backplane slot sense
	input  wire logic         i_aux_slot_connector,
	input  wire logic [4:0]   i_slot_pins,
	// status
	output logic              o_busy,
	output logic              o_data_ready
);
	qdc_buf_if bif ();
	qdc_event_mem u_mem (
		.i_clk   (i_clk),
		.i_reset (i_reset),
		.bus     (bif.mem)
	);
	asm_state_t   state_q;
	logic         aux_s1_q;
	logic         aux_s2_q;
	logic [4:0]   slot_s1_q;
	logic [4:0]   slot_s2_q;
	logic         slot_id_missing_flag;
	logic [4:0]   geo_q;
	logic [7:0]   crate_q;
	logic [15:0]  bs2_q;
	logic [8:0]   thr_q [0:31];
	logic [383:0] adc_q;
	logic [31:0]  ovf_q;
	logic [31:0]  below_limit_flag;
	logic [31:0]  keep;
	logic [4:0]   step_q;
	logic [5:0]   cnt_q;
	logic [23:0]  evcnt_q;
	logic [3:0]   lo;
	logic [4:0]   ch;
	logic [4:0]   last_step;
	logic [4:0]   ch_field;
	logic         store_evt;
	logic         take_gate;
	buf_word_t    data_word;
	buf_word_t    hdr_word;
	buf_word_t    event_trailer_word;
	logic         is_buf;
	logic         is_thr;
	logic         wr_known;
	logic         rd_known;
	logic         acc_ok;
	logic         rd_go;
	logic         wr_go;
	logic [31:0]  rd_val;

	// pin synchronisers
	always_ff @(posedge i_clk) begin
		aux_s1_q  <= i_aux_slot_connector;
		aux_s2_q  <= aux_s1_q;
		slot_s1_q <= i_slot_pins;
		slot_s2_q <= slot_s1_q;
	end
	assign slot_id_missing_flag = !aux_s2_q;
	// access decode
	assign is_buf = (i_addr <= `QDC_OFF_BUF_HI);
	assign is_thr = (i_addr >= `QDC_OFF_THR_LO) && (i_addr <= `QDC_OFF_THR_HI);
	assign wr_known = is_thr || (i_addr == `QDC_OFF_CRATE) || (i_addr == `QDC_OFF_BSET2)
		|| (i_addr == `QDC_OFF_BCLR2)
		|| ((i_addr == `QDC_OFF_GEO) && slot_id_missing_flag);
	assign rd_known = is_thr || (i_addr == `QDC_OFF_FWREV) || (i_addr == `QDC_OFF_GEO)
		|| (i_addr == `QDC_OFF_STAT1) || (i_addr == `QDC_OFF_CRATE) || (i_addr == `QDC_OFF_BSET2);

	// legality of the current request
	always_comb begin
		acc_ok = 1'b0;
		if (i_mcst) begin
			acc_ok = i_wr && !i_wide && (i_addr >= `QDC_MCST_LO)
				&& (i_addr <= `QDC_MCST_HI);
		end else if (is_buf) begin
			acc_ok = i_rd && i_wide;
		end else if (!i_wide) begin
			acc_ok = (i_rd && rd_known) || (i_wr && wr_known);
		end
	end

	assign rd_go = i_rd && acc_ok;
	assign wr_go = i_wr && acc_ok;
	assign bif.rd_en = rd_go && is_buf;
	// read data selection
	always_comb begin
		rd_val = 32'h0000_0000;
		if (is_buf) begin
			rd_val = bif.empty ? {5'h00, `QDC_TYPE_NVD, 24'h00_0000} : bif.rd_data;
		end else if (is_thr) begin
			rd_val = {23'h00_0000, thr_q[i_addr[5:1]]};
		end else begin
			case (i_addr)
				`QDC_OFF_FWREV: rd_val = {16'h0000, `QDC_FW_REV};
				`QDC_OFF_GEO:   rd_val = {27'h000_0000, geo_q};
				`QDC_OFF_CRATE: rd_val = {24'h00_0000, crate_q};
				`QDC_OFF_BSET2: rd_val = {16'h0000, bs2_q};
				`QDC_OFF_STAT1: begin
					rd_val[`QDC_ST_DRDY_BIT] = !bif.empty;
					rd_val[`QDC_ST_BUSY_BIT] = o_busy;
					rd_val[`QDC_ST_MISS_BIT] = slot_id_missing_flag;
				end
				default: rd_val = 32'h0000_0000;
			endcase
		end
	end

	// answer one cycle after the strobe
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_ack   <= 1'b0;
			o_berr  <= 1'b0;
			o_rdata <= 32'h0000_0000;
		end else begin
			o_ack  <= (i_rd || i_wr) && acc_ok;
			o_berr <= (i_rd || i_wr) && !acc_ok;
			if (rd_go) begin
				o_rdata <= rd_val;
			end
		end
	end

	// slot position: all ones at reset, backplane value when present
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			geo_q <= `QDC_GEO_RST;
		end else if (aux_s2_q) begin
			geo_q <= slot_s2_q;
		end else if (wr_go && (i_addr == `QDC_OFF_GEO)) begin
			geo_q <= i_wdata[4:0];
		end
	end

	// crate number and set/clear control word
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			crate_q <= `QDC_CRATE_RST;
			bs2_q   <= `QDC_BS2_RST;
		end else if (wr_go) begin
			if (i_addr == `QDC_OFF_CRATE) begin
				crate_q <= i_wdata[7:0];
			end
			if (i_addr == `QDC_OFF_BSET2) begin
				bs2_q <= bs2_q | i_wdata;
			end
			if (i_addr == `QDC_OFF_BCLR2) begin
				bs2_q <= bs2_q & ~i_wdata;
			end
		end
	end

	// per-channel threshold, below-limit test and keep decision
	for (genvar g = 0; g < 32; g++) begin : g_chan
		always_ff @(posedge i_clk) begin
			if (i_reset) begin
				thr_q[g] <= `QDC_THR_RST;
			end else if (wr_go && is_thr && (i_addr[5:1] == 5'(g))) begin
				thr_q[g] <= i_wdata[8:0];
			end
		end
		assign below_limit_flag[g] = adc_q[g*12 +: 12] < {thr_q[g][7:0], 4'h0};
		assign keep[g] = !thr_q[g][`QDC_THR_KILL_BIT]
			&& (!below_limit_flag[g] || bs2_q[`QDC_BS2_UND_BIT])
			&& (!ovf_q[g] || bs2_q[`QDC_BS2_OVF_BIT]);
	end

	// interleaved channel walk
	assign lo        = CH32 ? step_q[4:1] : {1'b0, step_q[3:1]};
	assign ch        = step_q[0] ? ((CH32 ? 5'h10 : 5'h08) + {1'b0, lo}) : {1'b0, lo};
	assign last_step = CH32 ? 5'h1F : 5'h0F;
	assign ch_field  = CH32 ? ch : {ch[3:0], 1'b0};
	assign store_evt = (cnt_q != 6'h00) || bs2_q[`QDC_BS2_UND_BIT];
	assign take_gate = i_gate_done && (state_q == ST_IDLE) && bif.room;

	// word formats
	assign data_word = {geo_q, `QDC_TYPE_DATA, 3'h0, ch_field, 2'h0,
		below_limit_flag[ch], ovf_q[ch], adc_q[ch*12 +: 12]};
	assign hdr_word = {geo_q, `QDC_TYPE_HDR, crate_q, 2'h0, cnt_q, 8'h00};
	assign event_trailer_word = {geo_q, `QDC_TYPE_TRAIL, evcnt_q};
	// capture of a finished conversion
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			adc_q <= 384'h0;
			ovf_q <= 32'h0000_0000;
		end else if (take_gate) begin
			adc_q <= i_adc;
			ovf_q <= i_ovf;
		end
	end

	// event counter, one per accepted gate
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			evcnt_q <= 24'h00_0000;
		end else if (take_gate) begin
			evcnt_q <= evcnt_q + 24'h00_0001;
		end
	end
	// assembly sequence
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_q <= ST_IDLE;
			step_q  <= 5'h00;
			cnt_q   <= 6'h00;
		end else begin
			case (state_q)
				ST_IDLE: begin
					step_q <= 5'h00;
					cnt_q  <= 6'h00;
					if (take_gate) begin
						state_q <= ST_SCAN;
					end
				end
				ST_SCAN: begin
					if (keep[ch]) begin
						cnt_q <= cnt_q + 6'h01;
					end
					step_q <= step_q + 5'h01;
					if (step_q == last_step) begin
						state_q <= ST_HEAD;
					end
				end
				ST_HEAD: begin
					state_q <= store_evt ? ST_TAIL : ST_IDLE;
				end
				ST_TAIL: begin
					state_q <= ST_IDLE;
				end
				default: begin
					state_q <= ST_IDLE;
				end
			endcase
		end
	end

	// store writes: data past the header slot, header after the data, trailer and publish together
	always_comb begin
		bif.wr_en      = 1'b0;
		bif.wr_off     = 6'h00;
		bif.wr_data    = 32'h0000_0000;
		bif.commit     = 1'b0;
		bif.commit_len = cnt_q + 6'h02;
		case (state_q)
			ST_SCAN: begin
				bif.wr_en   = keep[ch];
				bif.wr_off  = cnt_q + 6'h01;
				bif.wr_data = data_word;
			end
			ST_HEAD: begin
				bif.wr_en   = store_evt;
				bif.wr_data = hdr_word;
			end
			ST_TAIL: begin
				bif.wr_en   = 1'b1;
				bif.wr_off  = cnt_q + 6'h01;
				bif.wr_data = event_trailer_word;
				bif.commit  = 1'b1;
			end
			default: begin
				bif.wr_en = 1'b0;
			end
		endcase
	end

	// status outputs
	assign o_busy       = (state_q != ST_IDLE) || !bif.room;
	assign o_data_ready = !bif.empty;
	// checks
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	empty_read_a: assert property (
		(rd_go && is_buf && bif.empty) |=> (o_ack && (o_rdata[26:24] == 3'h6) && (o_rdata[31:27] == 5'h00)))
		else $error("empty buffer read did not give the not-valid word");
	buf_width_a: assert property (
		(i_rd && !i_mcst && is_buf && !i_wide) |=> (o_berr && !o_ack))
		else $error("narrow buffer read was accepted");
	mcst_read_a: assert property (
		(i_mcst && i_rd) |=> (o_berr && !o_ack))
		else $error("multicast read was accepted");
	buf_write_a: assert property (
		(i_wr && !i_mcst && is_buf) |=> o_berr)
		else $error("write to the buffer window was accepted");
	geo_lock_a: assert property (
		(i_wr && !i_mcst && !i_wide && (i_addr == `QDC_OFF_GEO) && aux_s2_q) |=> (o_berr && !o_ack))
		else $error("slot write accepted with backplane slot present");
	fw_read_a: assert property (
		(rd_go && (i_addr == `QDC_OFF_FWREV)) |=> (o_ack && (o_rdata == {16'h0000, `QDC_FW_REV})))
		else $error("firmware revision read wrong");
	header_fmt_a: assert property (
		((state_q == ST_HEAD) && bif.wr_en) |-> ((bif.wr_data[26:24] == 3'h2) && (bif.wr_data[23:16] == crate_q)
			&& (bif.wr_data[13:8] == cnt_q) && (bif.wr_data[31:27] == geo_q)))
		else $error("header word malformed");
	trailer_fmt_a: assert property (
		bif.commit |-> ((bif.wr_data[26:24] == 3'h4) && (bif.wr_data[23:0] == evcnt_q)
			&& (bif.wr_off == cnt_q + 6'h01)))
		else $error("trailer word malformed");
	zero_supp_a: assert property (
		((state_q == ST_HEAD) && (cnt_q == 6'h00) && !bs2_q[`QDC_BS2_UND_BIT])
			|-> (!bif.wr_en ##1 ((state_q == ST_IDLE) && !bif.commit)))
		else $error("empty suppressed event was stored");
	data_fmt_a: assert property (
		((state_q == ST_SCAN) && bif.wr_en) |-> ((bif.wr_data[26:24] == 3'h0)
			&& (bif.wr_data[12] == ovf_q[ch]) && (bif.wr_data[11:0] == adc_q[ch*12 +: 12])))
		else $error("data word malformed");
	scan_end_a: assert property (
		((state_q == ST_SCAN) && (step_q == last_step)) |=> (state_q == ST_HEAD))
		else $error("channel walk did not end at the last step");
	event_stored_c: cover property (bif.commit);
	empty_read_c: cover property (rd_go && is_buf && bif.empty);
	suppressed_c: cover property ((state_q == ST_HEAD) && !store_evt);
	geo_write_c: cover property (wr_go && (i_addr == `QDC_OFF_GEO));
endmodule

`default_nettype wire

// File: verif/qdc_bus_master.sv
// qdc_bus_master: register bus master model for the event readout
// assumes: strobes taken at a rising edge, answer one cycle after the strobe
`timescale 1ns/1ps
`default_nettype none

module qdc_bus_master (
	// clock
	input  wire logic        i_clk,
	// answer from the device
	input  wire logic        i_ack,
	input  wire logic        i_berr,
	input  wire logic [31:0] i_rdata,
	// request to the device
	output logic             o_rd,
	output logic             o_wr,
	output logic             o_wide,
	output logic             o_mcst,
	output logic [15:0]      o_addr,
	output logic [15:0]      o_wdata
);
	// idle bus at time zero
	initial begin
		o_rd = 1'b0;
		o_wr = 1'b0;
		o_wide = 1'b0;
		o_mcst = 1'b0;
		o_addr = 16'h0000;
		o_wdata = 16'h0000;
	end

	// one access: strobe for one edge, then take the answer once settled
	task automatic access(input logic rd, input logic wide, input logic mcst, input logic [15:0] addr,
		input logic [15:0] wdata, output logic [1:0] resp, output logic [31:0] data);
		@(posedge i_clk);
		o_rd <= rd;
		o_wr <= ~rd;
		o_wide <= wide;
		o_mcst <= mcst;
		o_addr <= addr;
		o_wdata <= wdata;
		@(posedge i_clk);
		o_rd <= 1'b0;
		o_wr <= 1'b0;
		o_addr <= ~addr; // released lines show the inverse, not the old value
		o_wdata <= ~wdata;
		#1;
		resp = {i_berr, i_ack};
		data = i_rdata;
	endtask
endmodule

`default_nettype wire

// File: verif/qdc_event_buffer_readout_tb.sv
// qdc_event_buffer_readout_tb: register checks and event readout of the 32-channel build
// assumes: qdc_bus_master drives the register port, bench drives conversion results
`timescale 1ns/1ps
`default_nettype none

module qdc_event_buffer_readout_tb;
	import qdc_pkg::*;
	logic          clk, reset, rd, wr, wide, mcst, ack, berr, gate_done, aux_conn, busy, data_ready;
	logic [15:0]   addr, wdata;
	logic [31:0]   rdata, ovf, q;
	logic [383:0]  adc;
	logic [4:0]    slot_pins;
	logic [23:0]   t1, t3;
	int            n_mismatch = 0;
	int            n_compared = 0;

	// device and bus master
	qdc_event_buffer_readout #(.CH32(1'b1)) dut_u (.i_clk(clk), .i_reset(reset), .i_rd(rd), .i_wr(wr),
		.i_wide(wide), .i_mcst(mcst), .i_addr(addr), .i_wdata(wdata), .o_ack(ack), .o_berr(berr),
		.o_rdata(rdata), .i_gate_done(gate_done), .i_adc(adc), .i_ovf(ovf),
		.i_aux_slot_connector(aux_conn), .i_slot_pins(slot_pins), .o_busy(busy), .o_data_ready(data_ready));
	qdc_bus_master bm_u (.i_clk(clk), .i_ack(ack), .i_berr(berr), .i_rdata(rdata), .o_rd(rd), .o_wr(wr),
		.o_wide(wide), .o_mcst(mcst), .o_addr(addr), .o_wdata(wdata));

	// 20 MHz clock
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// channel value: channel 7 sits below its threshold
	function automatic logic [11:0] val(input int ch);
		return (ch == 7) ? 12'h050 : 12'h200 + 12'(ch);
	endfunction

	// verdict and end of run
	task automatic end_sim;
		$display("compared %0d mismatched %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// compare and count
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: got %08h expected %08h", $time, got, exp);
		end
	endtask

	// one access with expected answer {berr, ack}
	task automatic xfer(input logic r, input logic w, input logic m, input logic [15:0] a,
		input logic [15:0] d, input logic [1:0] er);
		logic [1:0] resp;
		bm_u.access(r, w, m, a, d, resp, q);
		chk({30'h0, resp}, {30'h0, er});
	endtask

	// bounded wait for a level, counted as a mismatch on expiry
	task automatic wait_for(input logic want_ready);
		int k;
		for (k = 0; k < 100; k++) begin
			@(negedge clk);
			if (want_ready ? data_ready === 1'b1 : busy === 1'b0) break;
		end
		if (k == 100) begin
			n_mismatch++;
			end_sim();
		end
	endtask

	// one gate once the device is free
	task automatic gate(input logic [31:0] ov);
		wait_for(1'b0);
		@(posedge clk);
		gate_done <= 1'b1;
		ovf <= ov;
		@(posedge clk);
		gate_done <= 1'b0;
		@(negedge clk);
		chk({31'h0, busy}, 32'h1);
	endtask

	// read one event: header, interleaved data, trailer
	task automatic rd_event(input logic keep, output logic [23:0] cnt);
		int ch, n;
		n = 0;
		for (ch = 0; ch < 32; ch++) begin
			if (ch != 5 && (keep || (ch != 3 && ch != 7))) n++;
		end
		wait_for(1'b1);
		xfer(1'b1, 1'b1, 1'b0, 16'h0000, 16'h0000, 2'b01);
		chk(q & 32'hFFFF3F00, {5'h0B, 3'h2, 8'hA5, 2'b00, 6'(n), 8'h00});
		for (n = 0; n < 32; n++) begin
			ch = (n % 2 == 1) ? n / 2 + 16 : n / 2;
			if (ch == 5 || (!keep && (ch == 3 || ch == 7))) continue;
			xfer(1'b1, 1'b1, 1'b0, 16'(4 * n), 16'h0000, 2'b01);
			chk(q, {5'h0B, 6'h00, 5'(ch), 2'b00, ch == 7, ch == 3, val(ch)});
		end
		xfer(1'b1, 1'b1, 1'b0, 16'h07FC, 16'h0000, 2'b01);
		chk({q[31:24], 24'h0}, {5'h0B, 3'h4, 24'h0});
		cnt = q[23:0];
	endtask

	// main sequence
	initial begin
		int i;
		reset = 1'b1;
		gate_done = 1'b0;
		ovf = 32'h0;
		aux_conn = 1'b0;
		slot_pins = 5'h00;
		for (i = 0; i < 32; i++) adc[12 * i +: 12] = val(i);
		repeat (5) @(posedge clk);
		reset <= 1'b0;
		repeat (3) @(posedge clk);
		xfer(1'b1, 1'b1, 1'b0, 16'h0000, 16'h0000, 2'b01);
		chk(q, 32'h06000000);
		chk({31'h0, data_ready}, 32'h0);
		xfer(1'b1, 1'b0, 1'b0, 16'h1000, 16'h0000, 2'b01);
		chk({16'h0, q[15:0]}, 32'h00005A3C);
		xfer(1'b0, 1'b1, 1'b0, 16'h07FC, 16'h1234, 2'b10);
		xfer(1'b1, 1'b0, 1'b0, 16'h0004, 16'h0000, 2'b10);
		xfer(1'b1, 1'b1, 1'b0, 16'h1000, 16'h0000, 2'b10);
		xfer(1'b1, 1'b0, 1'b1, 16'h103C, 16'h0000, 2'b10);
		xfer(1'b0, 1'b1, 1'b1, 16'h103C, 16'h0011, 2'b10);
		xfer(1'b0, 1'b0, 1'b1, 16'h1004, 16'h0011, 2'b10);
		xfer(1'b0, 1'b0, 1'b1, 16'h10C0, 16'h0011, 2'b10);
		xfer(1'b0, 1'b0, 1'b1, 16'h103C, 16'h00A5, 2'b01);
		// slot written while the backplane gives no slot
		xfer(1'b0, 1'b0, 1'b0, 16'h1002, 16'h000B, 2'b01);
		xfer(1'b1, 1'b0, 1'b0, 16'h1002, 16'h0000, 2'b01);
		chk(q, 32'h0000000B);
		xfer(1'b0, 1'b0, 1'b0, 16'h108A, 16'h0100, 2'b01);
		xfer(1'b0, 1'b0, 1'b1, 16'h108E, 16'h0010, 2'b01);
		gate(32'h00000008);
		rd_event(1'b0, t1);
		xfer(1'b1, 1'b1, 1'b0, 16'h0000, 16'h0000, 2'b01);
		chk(q, 32'h06000000);
		// status: nothing stored, idle, slot missing
		xfer(1'b1, 1'b0, 1'b0, 16'h100E, 16'h0000, 2'b01);
		chk(q, 32'h00000010);
		// every channel overflowed and suppressed: no event at all
		gate(32'hFFFFFFFF);
		repeat (60) @(posedge clk);
		chk({31'h0, data_ready}, 32'h0);
		xfer(1'b0, 1'b0, 1'b0, 16'h1032, 16'h0018, 2'b01);
		gate(32'h00000008);
		rd_event(1'b1, t3);
		chk({8'h0, t3}, {8'h0, t1 + 24'h2});
		// clearing the under-threshold keep bit leaves the overflow keep bit
		xfer(1'b0, 1'b0, 1'b0, 16'h1034, 16'h0010, 2'b01);
		xfer(1'b1, 1'b0, 1'b0, 16'h1032, 16'h0000, 2'b01);
		chk(q, 32'h00000008);
		aux_conn <= 1'b1;
		slot_pins <= 5'h0D;
		repeat (5) @(posedge clk);
		xfer(1'b0, 1'b0, 1'b0, 16'h1002, 16'h0003, 2'b10);
		xfer(1'b1, 1'b0, 1'b0, 16'h1002, 16'h0000, 2'b01);
		chk(q, 32'h0000000D);
		end_sim();
	end
endmodule

`default_nettype wire
